// >>> hdl/host_parallel_uart_fifo_port.sv
// Purpose: Host parallel port with UART-style registers and 16-byte FIFOs
// Assumes: Host pins asynchronous to ref_clk, sampled through two flops
// Notes: Modem side exchanges bytes over valid/ready streams
//
// Overview of operation
// RULE1: Host spaces receive reads two CPU clocks plus 15ns
// RULE2: Host spaces transmit writes two CPU clocks plus 15ns
// RULE3: Receive FIFO holds up to sixteen bytes
// RULE4: Transmit FIFO holds up to sixteen bytes
// RULE5: FIFO enable bit turns both FIFOs on
// RULE6: DMA select acts only in FIFO mode
// RULE7: FIFOs off means single holding byte each
// RULE8: Data reads return oldest receive byte
// RULE9: Data writes append to transmit FIFO
// RULE10: Offset zero write with DIVISOR_LATCH_ACCESS clear loads transmit
// RULE11: Offset zero read with DIVISOR_LATCH_ACCESS clear returns receive
// RULE12: Access needs chip select and exactly one strobe
`default_nettype none

module host_parallel_uart_fifo_port (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic host_chip_select_n,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic [2:0] host_addr,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_oe,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   output logic dma_mode_active,
   output logic [15:0] divisor
);
   ////////////////////////////////////////////////////////////////////////////////
   host_port_pkg::host_bus_t raw_bus;
   host_port_pkg::host_bus_t meta_reg;
   host_port_pkg::host_bus_t sync_reg;
   logic rd_prev_reg;
   logic wr_prev_reg;
   logic rd_act;
   logic wr_act;
   logic rd_go;
   logic wr_go;

   assign raw_bus = {!host_chip_select_n, !host_read_strobe_n, !host_write_strobe_n,
                     host_addr, host_data_in};

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
         rd_prev_reg <= 1'b0;
         wr_prev_reg <= 1'b0;
      end else begin
         meta_reg <= raw_bus;
         sync_reg <= meta_reg;
         rd_prev_reg <= rd_act;
         wr_prev_reg <= wr_act;
      end
   end

   assign rd_act = sync_reg.cs && sync_reg.rd && !sync_reg.wr; // RULE12
   assign wr_act = sync_reg.cs && sync_reg.wr && !sync_reg.rd; // RULE12
   assign rd_go = rd_act && !rd_prev_reg;
   assign wr_go = wr_act && !wr_prev_reg;

   ////////////////////////////////////////////////////////////////////////////////
   logic fifo_mode_enable;
   logic fifo_dma_select;
   logic [7:0] line_ctrl_reg;
   logic [7:0] int_enable_reg;
   logic [7:0] modem_ctrl_reg;
   logic [7:0] scratch_reg;
   logic [7:0] div_lsb_reg;
   logic [7:0] div_msb_reg;
   logic divisor_latch_access;
   logic fifo_ctrl_wr;
   logic data_wr;
   logic data_rd;

   assign divisor_latch_access = line_ctrl_reg[host_port_pkg::LINE_DIVISOR_LATCH_ACCESS_BIT];
   assign fifo_ctrl_wr = wr_go && (sync_reg.addr == host_port_pkg::OFF_FIFO);
   assign data_wr = wr_go && (sync_reg.addr == host_port_pkg::OFF_DATA)
                    && !divisor_latch_access; // RULE10
   assign data_rd = rd_go && (sync_reg.addr == host_port_pkg::OFF_DATA)
                    && !divisor_latch_access; // RULE11

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         fifo_mode_enable <= 1'b0;
         fifo_dma_select <= 1'b0;
      end else if (fifo_ctrl_wr) begin
         fifo_mode_enable <= sync_reg.data[host_port_pkg::FIFO_EN_BIT]; // RULE5
         fifo_dma_select <= sync_reg.data[host_port_pkg::FIFO_DMA_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         line_ctrl_reg <= host_port_pkg::REG_RESET;
         int_enable_reg <= host_port_pkg::REG_RESET;
         modem_ctrl_reg <= host_port_pkg::REG_RESET;
         scratch_reg <= host_port_pkg::REG_RESET;
         div_lsb_reg <= host_port_pkg::REG_RESET;
         div_msb_reg <= host_port_pkg::REG_RESET;
      end else if (wr_go) begin
         unique case (sync_reg.addr)
            host_port_pkg::OFF_DATA: begin
               if (divisor_latch_access) begin
                  div_lsb_reg <= sync_reg.data;
               end
            end
            host_port_pkg::OFF_IER: begin
               if (divisor_latch_access) begin
                  div_msb_reg <= sync_reg.data;
               end else begin
                  int_enable_reg <= {4'h0, sync_reg.data[3:0]};
               end
            end
            host_port_pkg::OFF_LINE_CTRL: line_ctrl_reg <= sync_reg.data;
            host_port_pkg::OFF_MODEM_CTRL: modem_ctrl_reg <= {3'h0, sync_reg.data[4:0]};
            host_port_pkg::OFF_SCRATCH: scratch_reg <= sync_reg.data;
            host_port_pkg::OFF_FIFO, host_port_pkg::OFF_LINE_STAT,
            host_port_pkg::OFF_MODEM_STAT: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // FIFOs are flushed on reset bits and on any change of FIFO mode
   logic rx_clear;
   logic tx_clear;
   logic mode_flip;
   logic rx_push;
   logic rx_pop;
   logic rx_head_valid;
   logic [7:0] rx_head;
   logic [4:0] rx_count;
   logic [4:0] rx_limit;
   logic [4:0] rx_room;
   logic tx_accept;
   logic tx_pop;
   logic tx_in_ready;
   logic tx_head_valid;
   logic [7:0] tx_head;
   logic [4:0] tx_count;
   logic overrun_reg;

   assign mode_flip = sync_reg.data[host_port_pkg::FIFO_EN_BIT] != fifo_mode_enable;
   assign rx_clear = fifo_ctrl_wr && (mode_flip || sync_reg.data[host_port_pkg::FIFO_RX_RST_BIT]);
   assign tx_clear = fifo_ctrl_wr && (mode_flip || sync_reg.data[host_port_pkg::FIFO_TX_RST_BIT]);
   assign rx_limit = fifo_mode_enable ? 5'(host_port_pkg::FIFO_DEPTH) : 5'h1; // RULE7
   assign rx_room = rx_limit - rx_count;
   assign rx_push = rx_valid && rx_ready;
   assign rx_pop = data_rd && rx_head_valid; // RULE8
   assign tx_accept = data_wr && tx_in_ready
                      && (fifo_mode_enable || (tx_count == 5'h0)); // RULE9 RULE7
   assign tx_pop = tx_head_valid && (!tx_valid || tx_ready);

   byte_fifo #(.WIDTH(host_port_pkg::DATA_W), .DEPTH(host_port_pkg::FIFO_DEPTH),
               .CNT_W(host_port_pkg::CNT_W)) rx_fifo ( // RULE3
      .clk(ref_clk),
      .rst_n(rst_n),
      .clear(rx_clear),
      .in_valid(rx_push),
      .in_ready(),
      .in_data(rx_data),
      .out_valid(rx_head_valid),
      .out_ready(rx_pop),
      .out_data(rx_head),
      .count(rx_count)
   );

   byte_fifo #(.WIDTH(host_port_pkg::DATA_W), .DEPTH(host_port_pkg::FIFO_DEPTH),
               .CNT_W(host_port_pkg::CNT_W)) tx_fifo ( // RULE4
      .clk(ref_clk),
      .rst_n(rst_n),
      .clear(tx_clear),
      .in_valid(tx_accept),
      .in_ready(tx_in_ready),
      .in_data(sync_reg.data),
      .out_valid(tx_head_valid),
      .out_ready(tx_pop),
      .out_data(tx_head),
      .count(tx_count)
   );

   // Ready is registered, so it looks one push ahead
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rx_ready <= 1'b0;
      end else begin
         rx_ready <= !rx_clear && ((rx_room > 5'h1) || ((rx_room == 5'h1) && !rx_push));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
      end else if (tx_pop) begin
         tx_valid <= 1'b1;
         tx_data <= tx_head;
      end else if (tx_ready) begin
         tx_valid <= 1'b0;
      end
   end

   // Overrun set wins over the clear by a status read
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         overrun_reg <= 1'b0;
      end else if (rx_valid && !rx_ready && (rx_count == rx_limit)) begin
         overrun_reg <= 1'b1;
      end else if (rd_go && (sync_reg.addr == host_port_pkg::OFF_LINE_STAT)) begin
         overrun_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dma_mode_active <= 1'b0;
         divisor <= 16'h0000;
      end else begin
         dma_mode_active <= fifo_mode_enable && fifo_dma_select; // RULE6
         divisor <= {div_msb_reg, div_lsb_reg};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] read_value;
   logic tx_empty;

   assign tx_empty = (tx_count == 5'h0);

   always_comb begin
      read_value = 8'h00;
      unique case (sync_reg.addr)
         host_port_pkg::OFF_DATA: read_value = divisor_latch_access ? div_lsb_reg : rx_head;
         host_port_pkg::OFF_IER: read_value = divisor_latch_access ? div_msb_reg : int_enable_reg;
         host_port_pkg::OFF_FIFO: read_value = {fifo_mode_enable, fifo_mode_enable, 2'h0,
                                                host_port_pkg::IIR_NONE_PENDING};
         host_port_pkg::OFF_LINE_CTRL: read_value = line_ctrl_reg;
         host_port_pkg::OFF_MODEM_CTRL: read_value = modem_ctrl_reg;
         host_port_pkg::OFF_LINE_STAT: read_value = {1'b0, tx_empty && !tx_valid, tx_empty,
                                                     3'h0, overrun_reg, rx_head_valid};
         host_port_pkg::OFF_MODEM_STAT: read_value = host_port_pkg::MODEM_STAT_VALUE;
         host_port_pkg::OFF_SCRATCH: read_value = scratch_reg;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         host_data_out <= 8'h00;
         host_data_oe <= 1'b0;
      end else begin
         host_data_oe <= rd_act; // RULE12
         if (rd_go) begin
            host_data_out <= read_value; // RULE11
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_rx_depth_cap: assert property (rx_count <= 5'h10) // RULE3
      else $error("rx fifo above sixteen");
   a_tx_depth_cap: assert property (tx_count <= 5'h10) // RULE4
      else $error("tx fifo above sixteen");
   a_fifo_enable_write: assert property (fifo_ctrl_wr |=> // RULE5
      fifo_mode_enable == $past(sync_reg.data[0]))
      else $error("fifo enable not taken");
   a_dma_gated_mode: assert property (##1 dma_mode_active == // RULE6
      $past(fifo_mode_enable && fifo_dma_select))
      else $error("dma select outside fifo mode");
   a_legacy_single_byte: assert property ((!fifo_mode_enable && !$past(fifo_mode_enable)) |-> // RULE7
      (rx_count <= 5'h1) && (tx_count <= 5'h1))
      else $error("depth beyond one in legacy mode");
   a_read_pops_oldest: assert property ((rx_pop && !rx_push && !rx_clear) |=> // RULE8
      rx_count == $past(rx_count) - 5'h1)
      else $error("receive read did not pop");
   a_write_appends_tx: assert property ((tx_accept && !tx_pop && !tx_clear) |=> // RULE9
      tx_count == $past(tx_count) + 5'h1)
      else $error("transmit write not appended");
   a_write_loads_tx: assert property ((data_wr && fifo_mode_enable && tx_in_ready
      && !tx_clear) |-> ##2 tx_valid || (tx_count != 5'h0)) // RULE10
      else $error("offset zero write lost");
   a_read_gives_head: assert property (data_rd |=> host_data_out == $past(rx_head)) // RULE11
      else $error("offset zero read wrong byte");
   a_drive_needs_select: assert property (host_data_oe |-> // RULE12
      $past(sync_reg.cs && sync_reg.rd && !sync_reg.wr))
      else $error("data driven without read access");

   c_fifo_fill: cover property (rx_count == 5'h10);
   c_tx_stream: cover property (tx_valid && tx_ready ##1 tx_valid);
   c_overrun: cover property ($rose(overrun_reg));
endmodule : host_parallel_uart_fifo_port

`default_nettype wire

// >>> hdl/byte_fifo.sv
// Purpose: Shared constants and types for the host port, plus its byte FIFO
// Assumes: One clock, synchronous active-low reset
// Notes: FIFO count reports stored words; clear empties it in one cycle
`default_nettype none

package host_port_pkg;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = 5;
   localparam logic [2:0] OFF_DATA = 3'h0;
   localparam logic [2:0] OFF_IER = 3'h1;
   localparam logic [2:0] OFF_FIFO = 3'h2;
   localparam logic [2:0] OFF_LINE_CTRL = 3'h3;
   localparam logic [2:0] OFF_MODEM_CTRL = 3'h4;
   localparam logic [2:0] OFF_LINE_STAT = 3'h5;
   localparam logic [2:0] OFF_MODEM_STAT = 3'h6;
   localparam logic [2:0] OFF_SCRATCH = 3'h7;
   localparam int FIFO_EN_BIT = 0;
   localparam int FIFO_RX_RST_BIT = 1;
   localparam int FIFO_TX_RST_BIT = 2;
   localparam int FIFO_DMA_BIT = 3;
   localparam int LINE_DIVISOR_LATCH_ACCESS_BIT = 7;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] MODEM_STAT_VALUE = 8'h00;
   localparam logic [3:0] IIR_NONE_PENDING = 4'h1;

   typedef struct packed {
      logic cs;
      logic rd;
      logic wr;
      logic [2:0] addr;
      logic [7:0] data;
   } host_bus_t;
endpackage : host_port_pkg

module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int CNT_W = 5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [CNT_W-1:0] count
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [CNT_W-1:0] count_reg;
   logic push;
   logic pop;

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
   endfunction : ptr_inc

   assign in_ready = (count_reg != FULL);
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rd_ptr_reg];
   assign count = count_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || clear) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
         if (push && !pop) begin
            count_reg <= count_reg + CNT_W'(1);
         end else if (pop && !push) begin
            count_reg <= count_reg - CNT_W'(1);
         end
      end
   end
endmodule : byte_fifo

`default_nettype wire

// >>> bench/host_cpu_model.sv
// Purpose: Host processor model driving the parallel port pins
// Assumes: Pins change just after ref_clk rising edges
// Notes: Strobe low 5 cycles, high 4, far above sync needs
`default_nettype none

module host_cpu_model (
   input wire logic ref_clk,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [2:0] addr,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cs_n = 1'h1;
      rd_n = 1'h1;
      wr_n = 1'h1;
      addr = 3'h0;
      wdata = 8'h00;
   end

   // Drives the strobe levels it is given, so both can be low at once; gaps well over two CPU clocks
   task automatic access(input logic c, input logic r, input logic w, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(posedge ref_clk);
      cs_n <= c;
      rd_n <= r;
      wr_n <= w;
      addr <= a;
      wdata <= d;
      repeat (5) @(posedge ref_clk);
      q = rdata;
      cs_n <= 1'h1;
      rd_n <= 1'h1;
      wr_n <= 1'h1;
      // Released data lines do not keep the last value
      wdata <= ~d;
      repeat (4) @(posedge ref_clk);
   endtask : access
endmodule : host_cpu_model
`default_nettype wire

// >>> bench/host_parallel_uart_fifo_port_bench.sv
// Purpose: Self-checking bench for the host parallel port
// Assumes: Modem-side streams driven here, host pins by the model
// Notes: Exact legacy and FIFO depths checked through rx_ready
`default_nettype none

module host_parallel_uart_fifo_port_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk = 1'h0;
   logic rst_n = 1'h0;
   logic cs_n, rd_n, wr_n, oe, rx_valid, rx_ready, tx_valid, tx_ready, dma;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, q, rx_data, tx_data;
   logic [15:0] divisor;
   int errors = 0;
   int checks = 0;

   always #50 ref_clk = ~ref_clk;

   host_parallel_uart_fifo_port u_host_parallel_uart_fifo_port (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .host_chip_select_n(cs_n),
      .host_read_strobe_n(rd_n),
      .host_write_strobe_n(wr_n),
      .host_addr(addr),
      .host_data_in(wdata),
      .host_data_out(rdata),
      .host_data_oe(oe),
      .rx_valid(rx_valid),
      .rx_data(rx_data),
      .rx_ready(rx_ready),
      .tx_valid(tx_valid),
      .tx_data(tx_data),
      .tx_ready(tx_ready),
      .dma_mode_active(dma),
      .divisor(divisor)
   );

   host_cpu_model u_host_cpu_model (
      .ref_clk(ref_clk),
      .cs_n(cs_n),
      .rd_n(rd_n),
      .wr_n(wr_n),
      .addr(addr),
      .wdata(wdata),
      .rdata(rdata)
   );

   ////////////////////////////////////////
   task automatic summarize();
      if (errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      u_host_cpu_model.access(1'h0, 1'h1, 1'h0, a, d, q);
   endtask : wr

   task automatic rd(input logic [2:0] a);
      u_host_cpu_model.access(1'h0, 1'h0, 1'h1, a, 8'h00, q);
   endtask : rd

   // Offer one byte; a refusal within the bound is not a fault here
   task automatic push_rx(input logic [7:0] d, output logic ok);
      ok = 1'h0;
      @(posedge ref_clk);
      rx_data <= d;
      rx_valid <= 1'h1;
      for (int i = 0; i < 20 && !ok; i++) begin
         @(posedge ref_clk);
         ok = (rx_ready === 1'h1);
      end
      rx_valid <= 1'h0;
      rx_data <= ~d;
   endtask : push_rx

   task automatic rx_fill(input int exp_n);
      logic ok;
      int n;
      n = 0;
      ok = 1'h1;
      while (ok && n < 17) begin
         push_rx(8'h30 + n[7:0], ok);
         if (ok) n++;
      end
      chk("rx depth", exp_n[15:0], n[15:0]);
      for (int i = 0; i < n; i++) begin
         rd(3'h0);
         chk("rx byte", 8'h30 + i[7:0], q);
      end
   endtask : rx_fill

   task automatic tx_collect(input int n, input logic [7:0] base);
      int w;
      tx_ready <= 1'h1;
      for (int i = 0; i < n; i++) begin
         w = 0;
         do begin
            @(posedge ref_clk);
            w++;
         end while (tx_valid !== 1'h1 && w < 40);
         if (tx_valid !== 1'h1) begin
            errors++;
            summarize();
         end
         chk("tx byte", base + i[7:0], tx_data);
      end
      tx_ready <= 1'h0;
      repeat (4) @(posedge ref_clk);
      chk("tx idle", 16'h0000, tx_valid);
   endtask : tx_collect

   ////////////////////////////////////////
   task automatic scn_reset();
      chk("tx valid", 16'h0000, tx_valid);
      chk("data oe", 16'h0000, oe);
      chk("dma", 16'h0000, dma);
   endtask : scn_reset

   task automatic scn_legacy();
      rx_fill(1);
      wr(3'h0, 8'ha5);
      tx_collect(1, 8'ha5);
   endtask : scn_legacy

   task automatic scn_fifo();
      wr(3'h2, 8'h01);
      rx_fill(16);
      for (int i = 0; i < 16; i++) begin
         wr(3'h0, 8'h50 + i[7:0]);
      end
      tx_collect(16, 8'h50);
   endtask : scn_fifo

   task automatic scn_dma();
      wr(3'h2, 8'h08);
      chk("dma no fifo", 16'h0000, dma);
      wr(3'h2, 8'h09);
      chk("dma fifo", 16'h0001, dma);
      wr(3'h2, 8'h00);
      chk("dma off", 16'h0000, dma);
   endtask : scn_dma

   task automatic scn_divisor_latch_access();
      wr(3'h3, 8'h80);
      wr(3'h0, 8'h3c);
      wr(3'h1, 8'h12);
      chk("divisor", 16'h123c, divisor);
      rd(3'h0);
      chk("latch low", 16'h003c, q);
      wr(3'h3, 8'h00);
      repeat (4) @(posedge ref_clk);
      chk("tx latch", 16'h0000, tx_valid);
   endtask : scn_divisor_latch_access

   task automatic scn_strobes();
      u_host_cpu_model.access(1'h0, 1'h0, 1'h0, 3'h0, 8'h77, q);
      u_host_cpu_model.access(1'h1, 1'h1, 1'h0, 3'h0, 8'h66, q);
      repeat (4) @(posedge ref_clk);
      chk("tx stray", 16'h0000, tx_valid);
      wr(3'h0, 8'h99);
      tx_collect(1, 8'h99);
   endtask : scn_strobes

   ////////////////////////////////////////
   initial begin
      rx_valid = 1'h0;
      rx_data = 8'h00;
      tx_ready = 1'h0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
      scn_reset();
      scn_legacy();
      scn_fifo();
      scn_dma();
      scn_divisor_latch_access();
      scn_strobes();
      summarize();
   end
endmodule : host_parallel_uart_fifo_port_bench
`default_nettype wire
